// >>> logic/cpf_pkg.sv
// constants and types of the configuration packet front end
package cpf_pkg;
   // timing: power-up initialization window
   localparam int CLK_MHZ = 50;
   localparam int INIT_TIME_NS = 1000;
   localparam int INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int INIT_CNT_W = 8;
   // boundary-scan instruction register
   localparam int IR_W = 6;
   localparam logic [5:0] IR_AES_KEY = 6'h31;
   localparam logic [5:0] IR_USER_CODE = 6'h33;
   localparam logic [5:0] IR_FUSE_CTRL = 6'h34;
   localparam logic [5:0] IR_RESET = 6'h3F;
   // stream patterns
   localparam logic [31:0] SYNC_WORD = 32'hAA99_5566;
   localparam logic [31:0] WIDTH_PAT_A = 32'h0000_00BB;
   localparam logic [31:0] WIDTH_PAT_B = 32'h1122_0044;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
   // packet header fields
   localparam int TYPE_LSB = 29;
   localparam int OP_LSB = 27;
   localparam int ADDR_MSB = 26;
   localparam int ADDR_LSB = 13;
   localparam int WC1_MSB = 10;
   localparam int WC2_MSB = 26;
   localparam logic [2:0] PKT_TYPE1 = 3'h1;
   localparam logic [2:0] PKT_TYPE2 = 3'h2;
   localparam logic [1:0] OP_WRITE = 2'h2;
   // packet register addresses
   localparam logic [13:0] PR_CMD = 14'h0004;
   localparam logic [13:0] PR_CONTROL_REG_0 = 14'h0005;
   localparam logic [13:0] PR_MASK = 14'h0006;
   localparam logic [13:0] PR_CONFIG_OPTIONS_0 = 14'h0009;
   localparam logic [13:0] PR_IDCODE = 14'h000C;
   localparam logic [13:0] PR_CONFIG_OPTIONS_1 = 14'h000E;
   localparam logic [13:0] PR_WARM_BOOT_START_ADDRESS = 14'h0010;
   localparam logic [13:0] PR_TIMER = 14'h0011;
   localparam logic [13:0] PR_CRC_PRE = 14'h0013;
   localparam logic [13:0] PR_CONTROL_REG_1 = 14'h0018;
   // command codes
   localparam logic [4:0] CMD_NULL = 5'h00;
   localparam logic [4:0] CMD_CRC_ACCUMULATOR_RESET_CMD = 5'h07;
   localparam logic [4:0] CMD_SWITCH = 5'h09;
   localparam int FREQ_LSB = 17;
   localparam int FREQ_W = 6;
   // software register map (word index)
   localparam int REG_AW = 4;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_IRQ_MASK = 4'h1;
   localparam logic [3:0] REG_CONTROL = 4'h2;
   localparam logic [3:0] REG_STATE = 4'h3;
   localparam logic [3:0] REG_WARM_BOOT_START_ADDRESS = 4'h4;
   localparam logic [3:0] REG_CONFIG_OPTIONS_0 = 4'h5;
   localparam logic [3:0] REG_CONFIG_OPTIONS_1 = 4'h6;
   localparam logic [3:0] REG_TIMER = 4'h7;
   localparam logic [3:0] REG_CRC_PRE = 4'h8;
   localparam logic [3:0] REG_CRC_ACC = 4'h9;
   localparam logic [3:0] REG_CONTROL_REG_0 = 4'hA;
   localparam logic [3:0] REG_CONTROL_REG_1 = 4'hB;
   localparam logic [3:0] REG_FUSE_SEL = 4'hC;
   // status bits
   localparam int EV_W = 5;
   localparam int EV_SYNC = 0;
   localparam int EV_ID_ERR = 1;
   localparam int EV_CRC_RST = 2;
   localparam int EV_SWITCH = 3;
   localparam int EV_WIDTH = 4;
   // synchronised pin vector layout
   localparam int PIN_W = 38;
   localparam int PIN_CLK = 32;
   localparam int PIN_PAR = 33;
   localparam int PIN_TCK = 34;
   localparam int PIN_TDI = 35;
   localparam int PIN_SHIR = 36;
   localparam int PIN_UPIR = 37;
   typedef enum logic [4:0] {ST_INIT = 5'h01, ST_WIDTH = 5'h02, ST_HUNT = 5'h04, ST_HEADER = 5'h08,
      ST_DATA = 5'h10} cpf_state_type;
   typedef enum logic [1:0] {BW_8 = 2'h0, BW_16 = 2'h1, BW_32 = 2'h2} cpf_width_type;
endpackage

// >>> logic/cpf_front_end.sv
// configuration packet front end: scan fuse select, entry sequence, header decode
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module cpf_front_end #(
   parameter logic [31:0] DEVICE_ID = 32'h0F0F_1234 // arbitrary value
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [31:0] cfgData,
   input wire logic cfgClkPin,
   input wire logic parallelMode,
   input wire logic scanTck,
   input wire logic scanTdi,
   input wire logic scanShiftIr,
   input wire logic scanUpdateIr,
   output logic initDoneOut,
   output logic initDoneOe,
   output logic aesKeyFuseSelect,
   output logic userCodeFuseSelect,
   output logic fuseAccessControlSelect,
   output logic [cpf_pkg::FREQ_W-1:0] clkFreqSel,
   output logic clkSwitchPulse,
   output logic configError,
   input wire logic [cpf_pkg::REG_AW-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   output logic irq
);
   import cpf_pkg::*;

   cpf_state_type state;
   cpf_width_type busWidth, hitWidth;
   logic [PIN_W-1:0] pinMeta, pinSync;
   logic clkPrev, tckPrev, updPrev, cfgEdge, tckEdge, updEdge;
   logic [IR_W-1:0] irShift;
   logic [INIT_CNT_W-1:0] initCnt;
   logic initEnd, widthHit, wordValid, lastPart, dataHit, resyncReq;
   logic [31:0] raw, rawPrev, rawPrev2, asmWord, word, next_asm;
   logic [1:0] asmCnt;
   logic [2:0] hType;
   logic [1:0] hOp;
   logic [13:0] hAddr, target;
   logic [26:0] hdrCount, left;
   logic hdrWrite;
   logic [31:0] timer, warm_boot_start_address, crcPre, config_options_0, config_options_1, mask, control_reg_0, control_reg_1, crcAcc;
   logic [4:0] cmdCode;
   logic [EV_W-1:0] ev, status, irqMask, next_status;

   // one crc step over a whole word, msb first
   function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [31:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 31; i >= 0; i--) begin
         r = r[31] ^ d[i] ? {r[30:0], 1'b0} ^ CRC_POLY : {r[30:0], 1'b0};
      end
      return r;
   endfunction

   // software read decode
   function automatic logic [31:0] readMux(input logic [REG_AW-1:0] a);
      unique case (a)
         REG_STATUS: return {27'h000_0000, status};
         REG_IRQ_MASK: return {27'h000_0000, irqMask};
         REG_STATE: return {25'h000_0000, busWidth, state};
         REG_WARM_BOOT_START_ADDRESS: return warm_boot_start_address;
         REG_CONFIG_OPTIONS_0: return config_options_0;
         REG_CONFIG_OPTIONS_1: return config_options_1;
         REG_TIMER: return timer;
         REG_CRC_PRE: return crcPre;
         REG_CRC_ACC: return crcAcc;
         REG_CONTROL_REG_0: return control_reg_0;
         REG_CONTROL_REG_1: return control_reg_1;
         REG_FUSE_SEL: return {29'h0000_0000, fuseAccessControlSelect, userCodeFuseSelect, aesKeyFuseSelect};
         default: return WORD_RST;
      endcase
   endfunction

   // every pin crosses two flops; clock pins are sampled, not used as clocks
   always_ff @(posedge clk_sys) begin
      pinMeta <= {scanUpdateIr, scanShiftIr, scanTdi, scanTck, parallelMode, cfgClkPin, cfgData};
      pinSync <= pinMeta;
   end

   // edge finders look only at the second stage
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         clkPrev <= 1'b0;
         tckPrev <= 1'b0;
         updPrev <= 1'b0;
      end else begin
         clkPrev <= pinSync[PIN_CLK];
         tckPrev <= pinSync[PIN_TCK];
         updPrev <= pinSync[PIN_UPIR];
      end
   end

   assign cfgEdge = pinSync[PIN_CLK] & ~clkPrev;
   assign tckEdge = pinSync[PIN_TCK] & ~tckPrev;
   assign updEdge = pinSync[PIN_UPIR] & ~updPrev;
   assign raw = pinSync[31:0];

   // instruction shift, lsb leaves first like any scan register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irShift <= IR_RESET;
      end else if (tckEdge && pinSync[PIN_SHIR]) begin
         irShift <= {pinSync[PIN_TDI], irShift[IR_W-1:1]};
      end
   end

   // fuse data path selection; no packet register reaches the fuses
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         aesKeyFuseSelect <= 1'b0;
         userCodeFuseSelect <= 1'b0;
         fuseAccessControlSelect <= 1'b0;
      end else if (updEdge) begin
         aesKeyFuseSelect <= irShift == IR_AES_KEY;
         userCodeFuseSelect <= irShift == IR_USER_CODE;
         fuseAccessControlSelect <= irShift == IR_FUSE_CTRL;
      end
   end

   // initialization window; the pin is held low until it ends
   assign initEnd = initCnt == INIT_CNT_W'(INIT_CYCLES - 1);
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         initCnt <= '0;
         initDoneOe <= 1'b1;
         initDoneOut <= 1'b0;
      end else begin
         initDoneOut <= 1'b0;
         initDoneOe <= state == ST_INIT && !initEnd;
         if (state == ST_INIT) begin
            initCnt <= initCnt + 1'b1;
         end
      end
   end

   // width pattern seen on the raw lanes, widest match first
   always_comb begin
      hitWidth = BW_32;
      widthHit = 1'b0;
      if (raw == WIDTH_PAT_B && rawPrev == WIDTH_PAT_A) begin
         widthHit = 1'b1;
      end else if (raw[15:0] == WIDTH_PAT_B[15:0] && rawPrev[15:0] == WIDTH_PAT_B[31:16]) begin
         hitWidth = BW_16;
         widthHit = 1'b1;
      end else if (raw[7:0] == WIDTH_PAT_B[7:0] && rawPrev[7:0] == WIDTH_PAT_B[15:8]
            && rawPrev2[7:0] == WIDTH_PAT_B[23:16]) begin
         hitWidth = BW_8;
         widthHit = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rawPrev <= WORD_RST;
         rawPrev2 <= WORD_RST;
      end else if (cfgEdge) begin
         rawPrev <= raw;
         rawPrev2 <= rawPrev;
      end
   end

   // word assembly, first beat lands in the most significant lanes
   assign next_asm = busWidth == BW_16 ? {asmWord[15:0], raw[15:0]} : {asmWord[23:0], raw[7:0]};
   assign lastPart = busWidth == BW_32 || (busWidth == BW_16 && asmCnt == 2'h1) || asmCnt == 2'h3;
   always_ff @(posedge clk_sys) begin
      if (!rst_n || state == ST_INIT || state == ST_WIDTH) begin
         asmWord <= WORD_RST;
         asmCnt <= 2'h0;
         word <= WORD_RST;
         wordValid <= 1'b0;
      end else begin
         wordValid <= cfgEdge && lastPart;
         if (cfgEdge) begin
            asmWord <= next_asm;
            asmCnt <= lastPart ? 2'h0 : asmCnt + 2'h1;
            if (lastPart) begin
               word <= busWidth == BW_32 ? raw : next_asm;
            end
         end
      end
   end

   // header fields
   assign hType = word[31:TYPE_LSB];
   assign hOp = word[TYPE_LSB-1:OP_LSB];
   assign hAddr = word[ADDR_MSB:ADDR_LSB];
   assign hdrCount = hType == PKT_TYPE1 ? {16'h0000, word[WC1_MSB:0]} : word[WC2_MSB:0];
   assign hdrWrite = hOp == OP_WRITE && (hType == PKT_TYPE1 || hType == PKT_TYPE2);
   assign dataHit = state == ST_DATA && wordValid;
   assign resyncReq = regWrite && regAddr == REG_CONTROL && regWdata[0];

   // entry sequence and packet framing
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= ST_INIT;
         busWidth <= BW_32;
      end else if (resyncReq && state != ST_INIT) begin
         state <= ST_HUNT;
      end else begin
         unique case (state)
            ST_INIT: if (initEnd) begin
               state <= pinSync[PIN_PAR] ? ST_WIDTH : ST_HUNT;
            end
            ST_WIDTH: if (cfgEdge && widthHit) begin
               busWidth <= hitWidth;
               state <= ST_HUNT;
            end
            ST_HUNT: if (wordValid && word == SYNC_WORD) begin
               state <= ST_HEADER;
            end
            ST_HEADER: if (wordValid && hdrWrite && hdrCount != 27'h000_0000) begin
               state <= ST_DATA;
            end
            ST_DATA: if (wordValid && left == 27'h000_0001) begin
               state <= ST_HEADER;
            end
         endcase
      end
   end

   // target address and remaining word count; a second-type header reuses the address
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         target <= 14'h0000;
         left <= 27'h000_0000;
      end else if (state == ST_HEADER && wordValid && hdrWrite) begin
         left <= hdrCount;
         if (hType == PKT_TYPE1) begin
            target <= hAddr;
         end
      end else if (dataHit) begin
         left <= left - 27'h000_0001;
      end
   end

   // packet-written registers; frame data and unknown targets pass untouched
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         timer <= WORD_RST;
         warm_boot_start_address <= WORD_RST;
         crcPre <= WORD_RST;
         config_options_0 <= WORD_RST;
         config_options_1 <= WORD_RST;
         mask <= WORD_RST;
         control_reg_0 <= WORD_RST;
         control_reg_1 <= WORD_RST;
         cmdCode <= CMD_NULL;
      end else if (dataHit) begin
         case (target)
            PR_TIMER: timer <= word;
            PR_WARM_BOOT_START_ADDRESS: warm_boot_start_address <= word;
            PR_CMD: cmdCode <= word[4:0];
            PR_CRC_PRE: crcPre <= word;
            PR_CONFIG_OPTIONS_0: config_options_0 <= word;
            PR_CONFIG_OPTIONS_1: config_options_1 <= word;
            PR_MASK: mask <= word;
            PR_CONTROL_REG_0: control_reg_0 <= (control_reg_0 & ~mask) | (word & mask);
            PR_CONTROL_REG_1: control_reg_1 <= (control_reg_1 & ~mask) | (word & mask);
            default: ;
         endcase
      end
   end

   // block events; a null command raises none
   always_comb begin
      ev = '0;
      ev[EV_SYNC] = state == ST_HUNT && wordValid && word == SYNC_WORD;
      ev[EV_ID_ERR] = dataHit && target == PR_IDCODE && word != DEVICE_ID;
      ev[EV_CRC_RST] = dataHit && target == PR_CMD && word[4:0] == CMD_CRC_ACCUMULATOR_RESET_CMD;
      ev[EV_SWITCH] = dataHit && target == PR_CMD && word[4:0] == CMD_SWITCH;
      ev[EV_WIDTH] = state == ST_WIDTH && cfgEdge && widthHit;
   end

   // running crc; the reset command wins over its own word
   always_ff @(posedge clk_sys) begin
      if (!rst_n || ev[EV_CRC_RST]) begin
         crcAcc <= WORD_RST;
      end else if ((state == ST_HEADER || state == ST_DATA) && wordValid) begin
         crcAcc <= crcStep(crcAcc, word);
      end
   end

   // clock switch and configuration error outputs
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         clkFreqSel <= '0;
         clkSwitchPulse <= 1'b0;
         configError <= 1'b0;
      end else begin
         clkSwitchPulse <= ev[EV_SWITCH];
         configError <= configError | ev[EV_ID_ERR];
         if (ev[EV_SWITCH]) begin
            clkFreqSel <= config_options_0[FREQ_LSB +: FREQ_W];
         end
      end
   end

   // sticky status, write one to clear; a new event beats the clear
   assign next_status = (status & ~(regWrite && regAddr == REG_STATUS ? regWdata[EV_W-1:0] : '0)) | ev;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         status <= '0;
         irqMask <= '0;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         irq <= |(status & irqMask);
         if (regWrite && regAddr == REG_IRQ_MASK) begin
            irqMask <= regWdata[EV_W-1:0];
         end
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         regRdata <= WORD_RST;
      end else begin
         regRdata <= regRead ? readMux(regAddr) : WORD_RST;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_cmdWord;
      dataHit && target == PR_CMD;
   endsequence
   sequence s_syncSeen;
      state == ST_HUNT && wordValid && word == SYNC_WORD && !resyncReq;
   endsequence

   property p_fuseSelect;
      updEdge && irShift == IR_AES_KEY |=> aesKeyFuseSelect && !userCodeFuseSelect && !fuseAccessControlSelect;
   endproperty
   a_fuseSelect: assert property (p_fuseSelect) else $error("key fuse not selected");

   property p_initHold;
      state == ST_INIT |-> !wordValid ##1 (initDoneOe || state != ST_INIT);
   endproperty
   a_initHold: assert property (p_initHold) else $error("data or pin wrong during init");

   property p_syncEnter;
      s_syncSeen |=> state == ST_HEADER ##1 !ev[EV_SYNC];
   endproperty
   a_syncEnter: assert property (p_syncEnter) else $error("sync word not taken");

   property p_padDiscard;
      state == ST_HUNT && wordValid && word != SYNC_WORD |=> state == ST_HUNT;
   endproperty
   a_padDiscard: assert property (p_padDiscard) else $error("non-sync word left hunt");

   property p_widthFirst;
      $rose(state == ST_HUNT) && pinSync[PIN_PAR] |-> $past(state) != ST_INIT;
   endproperty
   a_widthFirst: assert property (p_widthFirst) else $error("parallel hunt before width");

   property p_headerOpen;
      state == ST_HEADER && wordValid && hdrWrite && hType == PKT_TYPE1 && hdrCount != 27'h000_0000
         && !resyncReq |=> state == ST_DATA && left == $past(hdrCount) && target == $past(hAddr);
   endproperty
   a_headerOpen: assert property (p_headerOpen) else $error("header not decoded");

   property p_cmdCode;
      s_cmdWord |=> cmdCode == $past(word[4:0]);
   endproperty
   a_cmdCode: assert property (p_cmdCode) else $error("command code not stored");

   property p_crcReset;
      s_cmdWord ##0 word[4:0] == CMD_CRC_ACCUMULATOR_RESET_CMD |=> crcAcc == WORD_RST && status[EV_CRC_RST];
   endproperty
   a_crcReset: assert property (p_crcReset) else $error("crc not cleared");

   property p_nullCmd;
      s_cmdWord ##0 word[4:0] == CMD_NULL |=> $stable(clkFreqSel) && !clkSwitchPulse;
   endproperty
   a_nullCmd: assert property (p_nullCmd) else $error("null command acted");

   property p_switch;
      s_cmdWord ##0 word[4:0] == CMD_SWITCH |=> clkSwitchPulse && clkFreqSel == $past(config_options_0[FREQ_LSB +: FREQ_W]);
   endproperty
   a_switch: assert property (p_switch) else $error("clock switch wrong");

   property p_idCheck;
      dataHit && target == PR_IDCODE && word != DEVICE_ID |=> configError ##1 configError;
   endproperty
   a_idCheck: assert property (p_idCheck) else $error("id mismatch not flagged");

   property p_maskGate;
      dataHit && target == PR_CONTROL_REG_0 |=> control_reg_0 == (($past(control_reg_0) & ~mask) | ($past(word) & mask));
   endproperty
   a_maskGate: assert property (p_maskGate) else $error("mask not applied");

   property p_warm_boot_start_address;
      dataHit && target == PR_WARM_BOOT_START_ADDRESS |=> warm_boot_start_address == $past(word) ##1 state != ST_INIT;
   endproperty
   a_warm_boot_start_address: assert property (p_warm_boot_start_address) else $error("warm boot address not written");
endmodule // cpf_front_end

// >>> testbench/cpf_source_model.sv
// configuration source model: link clock and data words
`timescale 1ns/100ps
module cpf_source_model (
   input wire logic clk_sys,
   input wire logic initDoneOe,
   output logic cfgClkPin,
   output logic [31:0] cfgData
);
   import cpf_pkg::*;
   // link clock stands low between words; data undriven shows a changing value
   initial begin
      cfgClkPin = 1'b0;
      cfgData = 32'h5A5A_A5A5;
   end
   // one word per beat, 160 ns link period when words follow back to back
   task automatic sendWord(input logic [31:0] w);
      while (initDoneOe !== 1'b0) @(posedge clk_sys);
      cfgData <= w;
      repeat (3) @(posedge clk_sys);
      cfgClkPin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      cfgClkPin <= 1'b0;
      cfgData <= ~w;
      // one more edge so the word's register writes have landed on return
      @(posedge clk_sys);
   endtask
endmodule // cpf_source_model

// >>> testbench/cpf_front_end_test.sv
// self-checking bench of the configuration packet front end
`timescale 1ns/100ps
module cpf_front_end_test;
   import cpf_pkg::*;
   localparam logic [31:0] ID = 32'h0BAD_0001; // arbitrary value
   logic clk_sys = 1'b0, rst_n = 1'b0, parallelMode = 1'b1, regWrite = 1'b0, regRead = 1'b0;
   logic scanTck = 1'b0, scanTdi = 1'b0, scanShiftIr = 1'b0, scanUpdateIr = 1'b0;
   logic [31:0] regWdata = 32'h0000_0000;
   logic [REG_AW-1:0] regAddr = 4'h0;
   logic [31:0] cfgData, regRdata;
   logic cfgClkPin, initDoneOut, initDoneOe, keySel, userSel, ctrlSel, clkSwitchPulse, configError, irq;
   logic [FREQ_W-1:0] clkFreqSel;
   logic [5:0] code [4] = '{IR_AES_KEY, IR_USER_CODE, IR_FUSE_CTRL, IR_RESET};
   // x8 width pattern, then the sync word, one beat per lane byte
   logic [7:0] x8Beats [9] = '{8'hBB, 8'h11, 8'h22, 8'h00, 8'h44, 8'hAA, 8'h99, 8'h55, 8'h66};
   int badCount = 0;
   int testsRun = 0;
   int pulseCount = 0;

   cpf_front_end #(.DEVICE_ID(ID)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .cfgData(cfgData),
      .cfgClkPin(cfgClkPin), .parallelMode(parallelMode), .scanTck(scanTck), .scanTdi(scanTdi),
      .scanShiftIr(scanShiftIr), .scanUpdateIr(scanUpdateIr), .initDoneOut(initDoneOut),
      .initDoneOe(initDoneOe), .aesKeyFuseSelect(keySel), .userCodeFuseSelect(userSel),
      .fuseAccessControlSelect(ctrlSel), .clkFreqSel(clkFreqSel), .clkSwitchPulse(clkSwitchPulse),
      .configError(configError), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata), .irq(irq));
   cpf_source_model src (.clk_sys(clk_sys), .initDoneOe(initDoneOe), .cfgClkPin(cfgClkPin), .cfgData(cfgData));

   // 50 MHz system clock
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   // one-cycle pulses are easy to miss, so count them
   always @(posedge clk_sys) begin
      if (clkSwitchPulse === 1'b1) pulseCount <= pulseCount + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      testsRun++;
      if (got !== exp) begin
         badCount++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic regWr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic regRd(input logic [3:0] a, input logic [31:0] exp, input string what);
      @(posedge clk_sys);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 chk(regRdata, exp, what);
   endtask
   // instruction bits go in low bit first
   task automatic scanIr(input logic [5:0] c);
      @(posedge clk_sys);
      scanShiftIr <= 1'b1;
      for (int i = 0; i < IR_W; i++) begin
         scanTdi <= c[i];
         repeat (4) @(posedge clk_sys);
         scanTck <= 1'b1;
         repeat (4) @(posedge clk_sys);
         scanTck <= 1'b0;
      end
      scanShiftIr <= 1'b0;
      repeat (4) @(posedge clk_sys);
      scanUpdateIr <= 1'b1;
      repeat (4) @(posedge clk_sys);
      scanUpdateIr <= 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic pkt(input logic [31:0] hdr, input logic [31:0] d);
      src.sendWord(hdr);
      src.sendWord(d);
   endtask
   // mid-run reset; the strap is read when init ends
   task automatic restart(input logic par);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      parallelMode <= par;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      #1 chk(initDoneOe, 1'b1, "init pin after reset");
      regRd(REG_STATE, 32'h0000_0041, "state after reset");
   endtask
   task automatic printVerdict();
      $display("comparisons %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // a hung handshake ends the run; about five times the expected length
   initial begin
      #100000;
      badCount++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      printVerdict();
   end

   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk_sys);
      #1 chk(initDoneOe, 1'b1, "init pin driven");
      chk(initDoneOut, 1'b0, "init pin low level");
      repeat (60) @(posedge clk_sys);
      #1 chk(initDoneOe, 1'b0, "init pin released");
      $display("test init finished");
      // each fuse code selects one register, the reset code none
      for (int k = 0; k < 4; k++) begin
         scanIr(code[k]);
         chk({ctrlSel, userSel, keySel}, (k < 3) ? (3'b001 << k) : 3'b000, "fuse select pins");
         regRd(REG_FUSE_SEL, (k < 3) ? (3'b001 << k) : 3'b000, "fuse select reg");
      end
      $display("test scan finished");
      src.sendWord(SYNC_WORD);
      regRd(REG_STATUS, 32'h0000_0000, "sync before width");
      src.sendWord(32'hFFFF_FFFF);
      src.sendWord(WIDTH_PAT_A);
      src.sendWord(WIDTH_PAT_B);
      regRd(REG_STATE, 32'h0000_0044, "width x32 hunting");
      src.sendWord(32'hFFFF_FFFF);
      regRd(REG_STATUS, 32'h0000_0010, "pad discarded");
      src.sendWord(SYNC_WORD);
      regRd(REG_STATE, 32'h0000_0048, "header after sync");
      regRd(REG_STATUS, 32'h0000_0011, "sync event");
      chk(irq, 1'b0, "irq masked");
      regWr(REG_IRQ_MASK, 32'h0000_0001);
      repeat (2) @(posedge clk_sys);
      #1 chk(irq, 1'b1, "irq raised");
      regWr(REG_STATUS, 32'h0000_0001);
      repeat (2) @(posedge clk_sys);
      #1 chk(irq, 1'b0, "irq cleared");
      regRd(4'hF, 32'h0000_0000, "unmapped read");
      $display("test entry finished");
      src.sendWord(32'h2000_0000);
      src.sendWord(32'h3002_2002);
      src.sendWord(32'h0000_1111);
      src.sendWord(32'h0000_0ABC);
      regRd(REG_TIMER, 32'h0000_0ABC, "timer two words");
      pkt(32'h3002_0001, 32'h0012_3400);
      regRd(REG_WARM_BOOT_START_ADDRESS, 32'h0012_3400, "warm boot");
      pkt(32'h3002_6001, 32'h0000_5A5A);
      regRd(REG_CRC_PRE, 32'h0000_5A5A, "crc reference");
      pkt(32'h3001_2001, 32'h0024_0000);
      regRd(REG_CONFIG_OPTIONS_0, 32'h0024_0000, "options zero");
      pkt(32'h3001_C001, 32'h0000_0003);
      regRd(REG_CONFIG_OPTIONS_1, 32'h0000_0003, "options one");
      pkt(32'h3000_C001, 32'h0000_00FF);
      pkt(32'h3000_A001, 32'h1234_5678);
      regRd(REG_CONTROL_REG_0, 32'h0000_0078, "masked control");
      pkt(32'h3000_8001, 32'h0000_0100);
      regRd(REG_STATUS, 32'h0000_0010, "null command");
      pkt(32'h3000_8001, 32'h0000_0107);
      regRd(REG_CRC_ACC, 32'h0000_0000, "crc cleared");
      chk(clkFreqSel, 6'h00, "freq before switch");
      pkt(32'h3000_8001, 32'h0000_0009);
      regRd(REG_STATUS, 32'h0000_001C, "command events");
      chk(clkFreqSel, 6'h12, "freq after switch");
      chk(pulseCount, 1, "switch pulse count");
      pkt(32'h3001_8001, ID);
      chk(configError, 1'b0, "id match");
      pkt(32'h3001_8001, ID ^ 32'h0000_0001);
      chk(configError, 1'b1, "id mismatch");
      regRd(REG_STATUS, 32'h0000_001E, "id error event");
      pkt(32'h3003_0001, 32'hFFFF_0F0F);
      regRd(REG_CONTROL_REG_1, 32'h0000_000F, "masked control one");
      regRd(REG_FUSE_SEL, 32'h0000_0000, "no fuse path from packets");
      $display("test packets finished");
      // mid-run resets: narrow parallel lanes, then the serial strap
      restart(1'b1);
      src.sendWord(32'h0000_00BB);
      src.sendWord(32'h0000_1122);
      src.sendWord(32'h0000_0044);
      src.sendWord(32'h0000_AA99);
      src.sendWord(32'h0000_5566);
      regRd(REG_STATE, 32'h0000_0028, "width x16 header");
      regRd(REG_STATUS, 32'h0000_0011, "x16 width and sync events");
      restart(1'b1);
      for (int k = 0; k < 9; k++) begin
         src.sendWord({24'h00_0000, x8Beats[k]});
      end
      regRd(REG_STATE, 32'h0000_0008, "width x8 header");
      restart(1'b0);
      src.sendWord(32'hFFFF_FFFF);
      src.sendWord(SYNC_WORD);
      regRd(REG_STATE, 32'h0000_0048, "serial header");
      regWr(REG_CONTROL, 32'h0000_0001);
      regRd(REG_STATE, 32'h0000_0044, "resync hunting");
      src.sendWord(32'h3000_8001);
      regRd(REG_STATE, 32'h0000_0044, "header before sync discarded");
      $display("test resets finished");
      printVerdict();
   end
endmodule // cpf_front_end_test
